/* File: include/adc_port_pkg.sv */
// Shared constants for the converter parallel output port.
// ============================================================
// Functional notes
// - The output word is offset binary when the format select is high and two's complement when it is low.
// - The range overflow flag is high with any sample that was over or under range and low otherwise.
// - The output sample clock is a delayed copy of the encode clock so that receivers can follow the data.
// - Data word and overflow flag change just after each falling edge of the output sample clock and stay stable through the next rise.
// - While the output enable input i_output_enable_n is low, data, overflow flag and output sample clock are released to high impedance.
// - Acquisition starts at each falling encode edge and the sampled value is held at the next rising edge.
// ============================================================
package adc_port_pkg;
  // ============================================================
  // Structure
  localparam int unsigned WORD_WIDTH     = 14;
  localparam int unsigned PIPE_LATENCY   = 5;
  localparam int unsigned FIFO_DEPTH     = 32;
  localparam int unsigned SYNC_STAGES    = 2;
  // ============================================================
  // Timing of the system clock and encode source, kept for reference only; no check reads them
  localparam int unsigned SYS_CLK_HZ     = 20_000_000;
  localparam int unsigned ENC_MAX_SPS    = 80_000_000;
  localparam int unsigned ENC_MIN_SPS    = 1_000_000;
  localparam int unsigned ENC_MIN_HALF_NS = 6;
  // ============================================================
  // Reset values
  localparam logic        RST_CLOCK_OUT  = 1'b0;
  localparam logic        RST_FLAG       = 1'b0;
  localparam logic        RST_OE         = 1'b0;
endpackage : adc_port_pkg

/* File: rtl/adc_parallel_output_port.sv */
// Output FIFO and top level of the converter parallel output port.
`timescale 1ns/1ns

// ============================================================
// FIFO
module adc_sample_fifo #(
  parameter int unsigned WIDTH = 15,
  parameter int unsigned DEPTH = adc_port_pkg::FIFO_DEPTH
) (
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_resetn,
  input  wire logic                     i_in_valid,
  output logic                          o_in_ready,
  input  wire logic [WIDTH-1:0]         i_in_data,
  output logic                          o_out_valid,
  input  wire logic                     i_out_ready,
  output logic      [WIDTH-1:0]         o_out_data,
  output logic      [$clog2(DEPTH):0]   o_count
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              push;
  wire              pop;
  wire  [AW-1:0]    last_ptr;

  assign last_ptr    = AW'(DEPTH - 1);
  assign o_in_ready  = (count != (AW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign push        = i_in_valid && o_in_ready;
  assign pop         = i_out_ready && o_out_valid;
  assign o_out_data  = mem[rd_ptr];
  assign o_count     = count;

  // Storage has no reset: the pointers and count say which words are valid.
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == last_ptr) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == last_ptr) ? '0 : rd_ptr + 1'b1;
      end
      case ({push, pop})
        2'b10:   count <= count + 1'b1;
        2'b01:   count <= count - 1'b1;
        default: count <= count;
      endcase
    end
  end
endmodule : adc_sample_fifo

// ============================================================
// Top level
module adc_parallel_output_port #(
  parameter int unsigned WIDTH   = adc_port_pkg::WORD_WIDTH,
  parameter int unsigned LATENCY = adc_port_pkg::PIPE_LATENCY,
  parameter int unsigned DEPTH   = adc_port_pkg::FIFO_DEPTH
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_resetn,
  input  wire logic             i_encode_clock_input,
  input  wire logic [WIDTH-1:0] i_conv_code,
  input  wire logic             i_conv_over_range,
  input  wire logic             i_conv_under_range,
  input  wire logic             i_output_format_select,
  input  wire logic             i_output_enable_n,
  output logic      [WIDTH-1:0] o_data,
  output logic      [WIDTH-1:0] o_data_oe,
  output logic                  o_range_overflow_flag,
  output logic                  o_range_overflow_flag_oe,
  output logic                  o_output_sample_clock,
  output logic                  o_output_sample_clock_oe,
  output logic                  o_sample_accept
);
  localparam int unsigned FW = WIDTH + 1;
  localparam int unsigned CW = $clog2(DEPTH) + 1;
  localparam int unsigned SN = adc_port_pkg::SYNC_STAGES;

  // ============================================================
  // Pin synchronisers: stage 0 is read only by stage 1
  logic [SN-1:0]    enc_sync;
  logic [SN-1:0]    fmt_sync;
  logic [SN-1:0]    oen_sync;
  logic [SN-1:0]    ovr_sync;
  logic [SN-1:0]    und_sync;
  logic [WIDTH-1:0] code_meta;
  logic [WIDTH-1:0] code_sync;
  logic             enc_prev;

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      enc_sync  <= '0;
      fmt_sync  <= '0;
      oen_sync  <= '0;
      ovr_sync  <= '0;
      und_sync  <= '0;
      code_meta <= '0;
      code_sync <= '0;
    end else begin
      enc_sync  <= {enc_sync[SN-2:0], i_encode_clock_input};
      fmt_sync  <= {fmt_sync[SN-2:0], i_output_format_select};
      oen_sync  <= {oen_sync[SN-2:0], i_output_enable_n};
      ovr_sync  <= {ovr_sync[SN-2:0], i_conv_over_range};
      und_sync  <= {und_sync[SN-2:0], i_conv_under_range};
      code_meta <= i_conv_code;
      code_sync <= code_meta;
    end
  end

  // Edge history reads the second stage only, never the first.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      enc_prev <= 1'b0;
    end else begin
      enc_prev <= enc_sync[SN-1];
    end
  end

  // ============================================================
  // Edge detection and decode
  wire             enc_level;
  wire             enc_rise;
  wire             enc_fall;
  wire             outputs_on;
  wire             in_ready;
  wire             out_valid;
  wire             primed;
  wire             pop;
  wire [FW-1:0]    in_word;
  wire [FW-1:0]    head_word;
  wire [CW-1:0]    fill;
  wire [WIDTH-1:0] msb_mask;
  wire [WIDTH-1:0] formatted;

  assign enc_level  = enc_sync[SN-1];
  assign enc_rise   = enc_level && !enc_prev;
  assign enc_fall   = !enc_level && enc_prev;
  assign outputs_on = oen_sync[SN-1];
  // Sample frozen at the rising encode edge that ends the acquisition
  // window opened at the preceding fall; the analog part lives outside.
  assign in_word    = {ovr_sync[SN-1] || und_sync[SN-1], code_sync};
  // Entries waiting in the FIFO stand for the conversion pipeline.
  // A hi-Z output stops draining, so the FIFO fills and refuses samples.
  // A backlog left by a long release is never trimmed, so the latency
  // stays longer than LATENCY until the next reset.
  assign primed     = (fill >= CW'(LATENCY));
  assign pop        = enc_fall && out_valid && outputs_on && primed;
  assign msb_mask   = {1'b1, {(WIDTH-1){1'b0}}};
  assign formatted  = fmt_sync[SN-1] ? head_word[WIDTH-1:0]
                                     : head_word[WIDTH-1:0] ^ msb_mask;

  adc_sample_fifo #(
    .WIDTH (FW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .i_clk_sys   (i_clk_sys),
    .i_resetn    (i_resetn),
    .i_in_valid  (enc_rise),
    .o_in_ready  (in_ready),
    .i_in_data   (in_word),
    .o_out_valid (out_valid),
    .i_out_ready (pop),
    .o_out_data  (head_word),
    .o_count     (fill)
  );

  // ============================================================
  // Output registers
  // One register behind the synchroniser keeps the copy aligned
  // with the data update that follows its fall.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_output_sample_clock <= adc_port_pkg::RST_CLOCK_OUT;
    end else begin
      o_output_sample_clock <= enc_level;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_sample_accept <= 1'b0;
    end else begin
      o_sample_accept <= in_ready;
    end
  end

  // Word and flag load together so a receiver never pairs a word
  // with the flag of its neighbour.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_data                <= '0;
      o_range_overflow_flag <= adc_port_pkg::RST_FLAG;
    end else if (pop) begin
      o_data                <= formatted;
      o_range_overflow_flag <= head_word[WIDTH];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_data_oe                <= '0;
      o_range_overflow_flag_oe <= adc_port_pkg::RST_OE;
      o_output_sample_clock_oe <= adc_port_pkg::RST_OE;
    end else begin
      o_data_oe                <= {WIDTH{outputs_on}};
      o_range_overflow_flag_oe <= outputs_on;
      o_output_sample_clock_oe <= outputs_on;
    end
  end
endmodule : adc_parallel_output_port

/* File: verification/adc_parallel_output_port_assertions.sv */
// Concurrent checks on the converter parallel output port.
`timescale 1ns/1ns
module adc_port_checker #(
  parameter int unsigned WIDTH = 14
) (
  input wire logic             i_clk_sys,
  input wire logic             i_resetn,
  input wire logic             i_encode_clock_input,
  input wire logic             i_output_enable_n,
  input wire logic [WIDTH-1:0] o_data,
  input wire logic [WIDTH-1:0] o_data_oe,
  input wire logic             o_range_overflow_flag,
  input wire logic             o_range_overflow_flag_oe,
  input wire logic             o_output_sample_clock,
  input wire logic             o_output_sample_clock_oe
);
  // ============================================================
  // Properties
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  wire logic oe;
  wire logic ck;
  assign oe = o_output_sample_clock_oe;
  assign ck = o_output_sample_clock;
  AST_OE_DATA: assert property (o_data_oe == {WIDTH{oe}})
    else $error("data enables differ from clock enable");
  AST_OE_FLAG: assert property (o_range_overflow_flag_oe == oe)
    else $error("flag enable differs from clock enable");
  AST_OE_OFF: assert property (!i_output_enable_n [*5] |-> !oe)
    else $error("outputs driven while disabled");
  AST_OE_ON: assert property (i_output_enable_n [*5] |-> oe)
    else $error("outputs released while enabled");
  AST_DATA_HOLD: assert property (!$fell(ck) |-> $stable(o_data))
    else $error("data word moved away from a clock fall");
  AST_FLAG_HOLD: assert property (
    !$fell(ck) |-> $stable(o_range_overflow_flag))
    else $error("flag moved away from a clock fall");
  AST_CLK_COPY: assert property (
    oe && $past(oe, 2) |-> ck == $past(i_encode_clock_input, 3))
    else $error("sample clock is not the delayed encode clock");
  AST_HOLD_OFF: assert property (
    !oe [*2] |-> $stable(o_data) && $stable(o_range_overflow_flag))
    else $error("outputs changed while released");
endmodule : adc_port_checker
bind adc_parallel_output_port adc_port_checker #(.WIDTH(WIDTH)) u_chk (
  .i_clk_sys, .i_resetn, .i_encode_clock_input, .i_output_enable_n,
  .o_data, .o_data_oe, .o_range_overflow_flag, .o_range_overflow_flag_oe,
  .o_output_sample_clock, .o_output_sample_clock_oe);

/* File: verification/adc_sample_receiver.sv */
// Receiving latch model on the far side of the output port.
`timescale 1ns/1ns
module adc_sample_receiver #(
  parameter int unsigned WIDTH = 14
) (
  input  wire logic             i_data_clock,
  input  wire logic             i_data_clock_oe,
  input  wire logic [WIDTH-1:0] i_data,
  input  wire logic             i_flag,
  output logic      [WIDTH-1:0] o_cap_data,
  output logic                  o_cap_flag,
  output logic      [15:0]      o_cap_count = 16'h0000
);
  // ============================================================
  // Capture
  // A released clock pin gives no edges, so nothing is latched then
  wire logic             pin_clk;
  wire logic [WIDTH-1:0] pin_data;
  wire logic             pin_flag;
  assign pin_clk = i_data_clock & i_data_clock_oe;
  // Released lines read back inverted, so a stray capture cannot pass
  assign pin_data = i_data_clock_oe ? i_data : ~i_data;
  assign pin_flag = i_data_clock_oe ? i_flag : ~i_flag;
  // Timing comes from the forwarded clock, never the encode source
  always @(posedge pin_clk) begin
    o_cap_data  <= pin_data;
    o_cap_flag  <= pin_flag;
    o_cap_count <= o_cap_count + 16'h0001;
  end
endmodule : adc_sample_receiver

/* File: verification/test_adc_parallel_output_port.sv */
// Self-checking bench for the converter parallel output port.
`timescale 1ns/1ns
module test_adc_parallel_output_port;
  localparam int unsigned W = adc_port_pkg::WORD_WIDTH;
  logic         i_clk_sys = 1'b0, i_resetn = 1'b0, encode_clock_input = 1'b0;
  logic [W-1:0] code = '0, o_data, o_data_oe, cap_data;
  logic         over = 1'b0, under = 1'b0, sel = 1'b1, oen = 1'b1;
  logic         flag, flag_oe, oclk, oclk_oe, accept, cap_flag;
  logic [15:0]  cap_count, seen = 16'h0000;
  logic [W:0]   exp_q[$];
  int           num_errors = 0, total_checks = 0, cycles = 0, skip = 0;
  bit           checking = 1'b1;
  // ============================================================
  // Design, receiver, clock
  always #25 i_clk_sys = ~i_clk_sys;
  adc_parallel_output_port u_dut (.i_clk_sys, .i_resetn,
    .i_encode_clock_input(encode_clock_input), .i_conv_code(code),
    .i_conv_over_range(over), .i_conv_under_range(under),
    .i_output_format_select(sel), .i_output_enable_n(oen), .o_data,
    .o_data_oe, .o_range_overflow_flag(flag),
    .o_range_overflow_flag_oe(flag_oe), .o_output_sample_clock(oclk),
    .o_output_sample_clock_oe(oclk_oe), .o_sample_accept(accept));
  adc_sample_receiver #(.WIDTH(W)) u_rx (.i_data_clock(oclk),
    .i_data_clock_oe(oclk_oe), .i_data(o_data), .i_flag(flag),
    .o_cap_data(cap_data), .o_cap_flag(cap_flag), .o_cap_count(cap_count));
  // ============================================================
  // Helpers
  function automatic logic [W:0] fmt(logic [W:0] e, logic s);
    return {e[W], s ? e[W-1:0] : e[W-1:0] ^ {1'b1, {(W-1){1'b0}}}};
  endfunction : fmt
  task automatic check(logic [W:0] seen_v, logic [W:0] exp_v);
    total_checks++;
    if (seen_v !== exp_v) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen_v, exp_v);
    end
  endtask : check
  task automatic sample(int n);
    repeat (n) begin
      @(posedge i_clk_sys);
      encode_clock_input   <= 1'b0;
      code  <= ($urandom_range(0, 3) == 0) ? {W{$urandom_range(0, 1) == 1}}
                                           : W'($urandom);
      over  <= $urandom_range(0, 3) == 0;
      under <= $urandom_range(0, 3) == 0;
      repeat (4) @(posedge i_clk_sys);
      encode_clock_input <= 1'b1;
      if (checking) exp_q.push_back({over | under, code});
      repeat (3) @(posedge i_clk_sys);
    end
  endtask : sample
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  // ============================================================
  // Capture monitor and hang guard
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles > 2000) begin
      num_errors++;
      finish_test();
    end else begin
      if (cap_count != seen && checking && exp_q.size() > 0) begin
        if (skip > 0) skip--;
        else check({cap_flag, cap_data}, fmt(exp_q[0], sel));
        void'(exp_q.pop_front());
      end
      seen = cap_count;
    end
  end
  // ============================================================
  // Sequence
  initial begin
    void'($urandom(44));
    // The first captures show words from before the pipeline filled
    for (int i = 0; i < adc_port_pkg::PIPE_LATENCY; i++) exp_q.push_back('0);
    repeat (20) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    sample(40);
    check({W'(0), accept}, (W+1)'(1));
    $display("offset binary test done");
    sel <= 1'b0;
    skip = 1;
    sample(40);
    $display("twos complement test done");
    checking = 1'b0;
    oen <= 1'b0;
    sample(40);
    check({flag_oe, o_data_oe}, '0);
    check({W'(0), oclk_oe | accept}, '0);
    oen <= 1'b1;
    sample(4);
    check({oclk_oe & flag_oe, o_data_oe}, '1);
    $display("output enable test done");
    finish_test();
  end
endmodule : test_adc_parallel_output_port
